// >>> hw/ccs_top.sv
// Comparator control and status: APB register file, input selection, compare, state and flag.
// Assumes input levels arrive asynchronously from pins; standby_sleep and clk_en come from pclk logic.
//
// Summary of operation
// - The comparator runs only while the enable bit of the control register is one.
// - The inversion bit flips the result for every consumer, state and flag logic included.
// - The positive source bit picks positive pin zero for 0 and positive pin one for 1.
// - The negative source field picks pin zero, pin one, the reference or the DAC output for 0 to 3.
// - Bit 0 of the interrupt enable register lets the comparator interrupt through.
// - Status bit 4 is read only and shows the result three clock cycles after the pins change.
// - Status bit 0 is the interrupt flag, cleared by writing one and kept by writing zero.
// - The raw result is one when the positive input exceeds the negative input, else zero.
// - The edge field sets the flag on both edges for 0, falling for 2 and rising for 3, never for 1.
// - The interrupt line is high while the flag is set and enabled, until software clears the flag.
// - In standby with run-in-sleep set the comparator keeps running but status and interrupt freeze.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps

module ccs_top (
  input wire logic pclk, // APB clock, 100 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic clk_en, // Freezes all state while low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [ccs_pkg::ADDR_W-1:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [3:0] pstrb, // APB write strobes.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped address.
  input wire logic standby_sleep, // Standby sleep mode is active.
  input wire logic [ccs_pkg::LEVEL_W-1:0] positive_pin_zero, // Level on positive pin zero.
  input wire logic [ccs_pkg::LEVEL_W-1:0] positive_pin_one, // Level on positive pin one.
  input wire logic [ccs_pkg::LEVEL_W-1:0] negative_pin_zero, // Level on negative pin zero.
  input wire logic [ccs_pkg::LEVEL_W-1:0] negative_pin_one, // Level on negative pin one.
  input wire logic [ccs_pkg::LEVEL_W-1:0] vref_level, // Voltage reference level.
  input wire logic [ccs_pkg::LEVEL_W-1:0] dac_level, // DAC output level.
  output logic comparator_result, // Comparator output after inversion.
  output logic comparator_on, // Comparator is enabled.
  output logic positive_source_sel, // Positive source selection.
  output logic [1:0] negative_source_sel, // Negative source selection.
  output logic irq // Level interrupt request.
);

  ccs_pkg::ccs_control_s control_reg;
  ccs_pkg::ccs_input_select_s select_reg;
  logic irq_enable_reg;
  logic flag_reg;
  logic flag_next;
  logic state_reg;
  logic state_prev_reg;
  logic result_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic irq_reg;

  ccs_pkg::ccs_level_t level_in [ccs_pkg::NUM_LEVELS];
  ccs_pkg::ccs_level_t level_meta [ccs_pkg::NUM_LEVELS];
  ccs_pkg::ccs_level_t level_sync [ccs_pkg::NUM_LEVELS];

  ccs_pkg::ccs_level_t pos_level;
  ccs_pkg::ccs_level_t neg_level;
  logic raw_result;
  logic result_next;
  logic halted;
  logic status_frozen;
  logic rise;
  logic fall;
  logic edge_hit;

  logic setup;
  logic access_done;
  logic wr;
  logic hit;
  logic [31:0] read_word;
  logic [3:0] idx;
  logic [7:0] wbyte;

  // Input level synchronisers.

  assign level_in[ccs_pkg::LVL_POS0] = positive_pin_zero;
  assign level_in[ccs_pkg::LVL_POS1] = positive_pin_one;
  assign level_in[ccs_pkg::LVL_NEG0] = negative_pin_zero;
  assign level_in[ccs_pkg::LVL_NEG1] = negative_pin_one;
  assign level_in[ccs_pkg::LVL_VREF] = vref_level;
  assign level_in[ccs_pkg::LVL_DAC] = dac_level;

  // Each level passes two flip-flops; the first is read only by the second.
  for (genvar g = 0; g < ccs_pkg::NUM_LEVELS; g++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        level_meta[g] <= '0;
        level_sync[g] <= '0;
      end else if (clk_en) begin
        level_meta[g] <= level_in[g];
        level_sync[g] <= level_meta[g];
      end
    end
  end

  // Input selection and compare.

  always_comb begin
    if (select_reg.positive_source_sel) begin
      pos_level = level_sync[ccs_pkg::LVL_POS1];
    end else begin
      pos_level = level_sync[ccs_pkg::LVL_POS0];
    end
  end

  always_comb begin
    case (select_reg.negative_source_sel)
      ccs_pkg::NEG_PIN_ZERO: neg_level = level_sync[ccs_pkg::LVL_NEG0];
      ccs_pkg::NEG_PIN_ONE: neg_level = level_sync[ccs_pkg::LVL_NEG1];
      ccs_pkg::NEG_VREF: neg_level = level_sync[ccs_pkg::LVL_VREF];
      ccs_pkg::NEG_DAC: neg_level = level_sync[ccs_pkg::LVL_DAC];
      default: neg_level = level_sync[ccs_pkg::LVL_NEG0];
    endcase
  end

  assign raw_result = (pos_level > neg_level);
  assign result_next = raw_result ^ select_reg.invert;

  // Standby without run-in-sleep halts the comparator; any standby freezes status.
  assign halted = standby_sleep & ~control_reg.keep_running_in_sleep;
  assign status_frozen = standby_sleep;

  // Third stage: the inverted result, held at zero while disabled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= 1'b0;
    end else if (clk_en) begin
      if (!control_reg.enable) begin
        result_reg <= 1'b0;
      end else if (!halted) begin
        result_reg <= result_next;
      end
    end
  end

  // The state bit is loaded at the same edge as the result, three edges after the pins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= 1'b0;
    end else if (clk_en) begin
      if (!control_reg.enable) begin
        state_reg <= 1'b0;
      end else if (!halted && !status_frozen) begin
        state_reg <= result_next;
      end
    end
  end

  // Edge detection on the synchronised, inverted state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_prev_reg <= 1'b0;
    end else if (clk_en) begin
      state_prev_reg <= state_reg;
    end
  end

  assign rise = state_reg & ~state_prev_reg;
  assign fall = ~state_reg & state_prev_reg;

  always_comb begin
    case (control_reg.irq_edge_select)
      ccs_pkg::EDGE_ANY: edge_hit = rise | fall;
      ccs_pkg::EDGE_RESERVED: edge_hit = 1'b0;
      ccs_pkg::EDGE_FALL: edge_hit = fall;
      ccs_pkg::EDGE_RISE: edge_hit = rise;
      default: edge_hit = 1'b0;
    endcase
  end

  // APB slave.

  assign setup = psel & ~penable;
  assign access_done = psel & penable & pready_reg;
  assign wr = access_done & pwrite & ~pslverr_reg & pstrb[0];
  assign idx = paddr[5:2];
  assign wbyte = pwdata[7:0];

  // Decode and read data, evaluated in the setup cycle and registered.
  always_comb begin
    read_word = '0;
    hit = (paddr[1:0] == 2'h0) && (paddr[ccs_pkg::ADDR_W-1:6] == '0);
    case (idx)
      ccs_pkg::IDX_CONTROL: begin
        read_word[ccs_pkg::CTRL_ENABLE_BIT] = control_reg.enable;
        read_word[ccs_pkg::CTRL_EDGE_LSB +: 2] = control_reg.irq_edge_select;
        read_word[ccs_pkg::CTRL_RUN_BIT] = control_reg.keep_running_in_sleep;
      end
      ccs_pkg::IDX_INPUT_SELECT: begin
        read_word[ccs_pkg::SEL_NEG_LSB +: 2] = select_reg.negative_source_sel;
        read_word[ccs_pkg::SEL_POS_BIT] = select_reg.positive_source_sel;
        read_word[ccs_pkg::SEL_INVERT_BIT] = select_reg.invert;
      end
      ccs_pkg::IDX_IRQ_ENABLE: begin
        read_word[ccs_pkg::IRQ_CMP_BIT] = irq_enable_reg;
      end
      ccs_pkg::IDX_STATUS: begin
        read_word[ccs_pkg::STAT_FLAG_BIT] = flag_reg;
        read_word[ccs_pkg::STAT_STATE_BIT] = state_reg;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // Every access completes in its first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else if (clk_en) begin
      pready_reg <= setup;
      pslverr_reg <= setup & ~hit;
      if (setup && !pwrite && hit) begin
        prdata_reg <= read_word;
      end else begin
        prdata_reg <= '0;
      end
    end
  end

  // Control register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg <= '0;
    end else if (clk_en && wr && idx == ccs_pkg::IDX_CONTROL) begin
      control_reg.enable <= wbyte[ccs_pkg::CTRL_ENABLE_BIT];
      control_reg.irq_edge_select <= wbyte[ccs_pkg::CTRL_EDGE_LSB +: 2];
      control_reg.keep_running_in_sleep <= wbyte[ccs_pkg::CTRL_RUN_BIT];
    end
  end

  // Input selection register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      select_reg <= '0;
    end else if (clk_en && wr && idx == ccs_pkg::IDX_INPUT_SELECT) begin
      select_reg.negative_source_sel <= wbyte[ccs_pkg::SEL_NEG_LSB +: 2];
      select_reg.positive_source_sel <= wbyte[ccs_pkg::SEL_POS_BIT];
      select_reg.invert <= wbyte[ccs_pkg::SEL_INVERT_BIT];
    end
  end

  // Interrupt enable, which masks the interrupt line but not the status flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_reg <= 1'b0;
    end else if (clk_en && wr && idx == ccs_pkg::IDX_IRQ_ENABLE) begin
      irq_enable_reg <= wbyte[ccs_pkg::IRQ_CMP_BIT];
    end
  end

  // Flag: a detected edge wins over a clear in the same cycle.
  always_comb begin
    flag_next = flag_reg;
    if (wr && idx == ccs_pkg::IDX_STATUS && wbyte[ccs_pkg::STAT_FLAG_BIT]) begin
      flag_next = 1'b0;
    end
    if (edge_hit && control_reg.enable && !status_frozen) begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= 1'b0;
    end else if (clk_en) begin
      flag_reg <= flag_next;
    end
  end

  // Level interrupt, held until the flag is cleared.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else if (clk_en) begin
      irq_reg <= flag_reg & irq_enable_reg;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign comparator_result = result_reg;
  assign comparator_on = control_reg.enable;
  assign positive_source_sel = select_reg.positive_source_sel;
  assign negative_source_sel = select_reg.negative_source_sel;
  assign irq = irq_reg;

endmodule

// >>> hw/ccs_pkg.sv
// Constants, field layouts and carrier types of the comparator control and status block.
// Assumes a 32-bit APB slave port with each register in one aligned word.
package ccs_pkg;

  // Width of one sampled input level word.
  localparam int LEVEL_W = 10;
  localparam int NUM_LEVELS = 6;
  localparam int ADDR_W = 8;

  // Register indices; the byte address is four times the index.
  localparam logic [3:0] IDX_CONTROL = 4'h0;
  localparam logic [3:0] IDX_INPUT_SELECT = 4'h2;
  localparam logic [3:0] IDX_IRQ_ENABLE = 4'h6;
  localparam logic [3:0] IDX_STATUS = 4'h7;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Field positions.
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_EDGE_LSB = 4;
  localparam int CTRL_RUN_BIT = 7;
  localparam int SEL_NEG_LSB = 0;
  localparam int SEL_POS_BIT = 3;
  localparam int SEL_INVERT_BIT = 7;
  localparam int IRQ_CMP_BIT = 0;
  localparam int STAT_FLAG_BIT = 0;
  localparam int STAT_STATE_BIT = 4;

  // Edge selections for the interrupt flag.
  localparam logic [1:0] EDGE_ANY = 2'h0;
  localparam logic [1:0] EDGE_RESERVED = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_RISE = 2'h3;

  // Negative source codes.
  localparam logic [1:0] NEG_PIN_ZERO = 2'h0;
  localparam logic [1:0] NEG_PIN_ONE = 2'h1;
  localparam logic [1:0] NEG_VREF = 2'h2;
  localparam logic [1:0] NEG_DAC = 2'h3;

  // Positions of the input levels in the sampled array.
  localparam int LVL_POS0 = 0;
  localparam int LVL_POS1 = 1;
  localparam int LVL_NEG0 = 2;
  localparam int LVL_NEG1 = 3;
  localparam int LVL_VREF = 4;
  localparam int LVL_DAC = 5;

  // Cycles from a pin change to the state bit.
  localparam int STATE_DELAY_CYCLES = 3;

  typedef logic [LEVEL_W-1:0] ccs_level_t;

  typedef struct packed {
    logic keep_running_in_sleep;
    logic [1:0] irq_edge_select;
    logic enable;
  } ccs_control_s;

  typedef struct packed {
    logic invert;
    logic positive_source_sel;
    logic [1:0] negative_source_sel;
  } ccs_input_select_s;

endpackage

// >>> sim/ccs_top_props.sv
// Port checks for the comparator control and status block.
// Assumes it is bound to ccs_top and that pclk clocks every input.
`timescale 1ns/1ps

module ccs_top_props (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic clk_en, // Clock enable.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [31:0] prdata, // APB read data.
  input wire logic pready, // APB ready.
  input wire logic pslverr, // APB error.
  input wire logic comparator_result, // Compare result.
  input wire logic comparator_on, // Enable state.
  input wire logic irq // Interrupt.
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic acc_w;
  assign acc_w = psel && penable && pwrite;
  pready_after_setup_a: assert property (psel && !penable && clk_en |=> pready)
    else $error("no ready after setup");
  pready_single_a: assert property (pready && clk_en |=> !pready)
    else $error("ready longer than one cycle");
  rdata_idle_zero_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  irq_clear_write_a: assert property ($fell(irq) |-> $past(acc_w, 2))
    else $error("interrupt dropped without a write");
  enable_change_write_a: assert property ($changed(comparator_on) |-> $past(acc_w) || $past(acc_w, 2))
    else $error("enable changed without a write");
  off_result_low_a: assert property ((!comparator_on && clk_en) [*6] |-> !comparator_result)
    else $error("result high while disabled");
  freeze_hold_a: assert property (!clk_en |=> $stable({irq, comparator_result, comparator_on}))
    else $error("state moved while frozen");
  cover property (acc_w && pready);
  cover property ($rose(irq));
  cover property ($rose(comparator_result));
endmodule

bind ccs_top ccs_top_props ccs_props_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .comparator_result(comparator_result), .comparator_on(comparator_on), .irq(irq));

// >>> sim/testbench.sv
// Self-checking bench for the comparator control and status block.
// Assumes the package, the design and the bound checker are compiled before it.
`timescale 1ns/1ps

module testbench;
  typedef struct packed {
    logic [7:0] sel;
    logic [9:0] pv;
    logic [9:0] nv;
    logic exp;
  } ccs_row_s;
  localparam logic [7:0] A_CTRL = 8'h00, A_SEL = 8'h08, A_IRQ = 8'h18, A_STAT = 8'h1c;
  logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic standby_sleep = 1'b0, erv;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdv, prdata;
  logic [3:0] pstrb = 4'hf;
  logic [9:0] pp0 = 10'h0, pp1 = 10'h0, np0 = 10'h0, np1 = 10'h0, vref = 10'h0, dac = 10'h0;
  logic pready, pslverr, comparator_result, comparator_on, positive_source_sel, irq;
  logic [1:0] negative_source_sel;
  int errors = 0, cmp_count = 0;
  ccs_row_s rows [6] = '{'{8'h00, 10'h101, 10'h100, 1'b1}, '{8'h01, 10'h100, 10'h100, 1'b0},
    '{8'h0a, 10'h200, 10'h1ff, 1'b1}, '{8'h0b, 10'h000, 10'h001, 1'b0},
    '{8'h83, 10'h3ff, 10'h000, 1'b0}, '{8'h8a, 10'h005, 10'h006, 1'b1}};

  ccs_top dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .standby_sleep(standby_sleep), .positive_pin_zero(pp0), .positive_pin_one(pp1),
    .negative_pin_zero(np0), .negative_pin_one(np1), .vref_level(vref), .dac_level(dac),
    .comparator_result(comparator_result), .comparator_on(comparator_on),
    .positive_source_sel(positive_source_sel), .negative_source_sel(negative_source_sel), .irq(irq));

  always #5 pclk = ~pclk;

  task automatic report_and_stop;
    if (errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      errors++;
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic ee);
    apb(1'b0, a, 8'h00, 4'hf);
    chk32(rdv, {24'h0, e});
    chk1(erv, ee);
  endtask

  // Unselected sources get levels that would flip the result, so a wrong route shows.
  task automatic pins(input logic [7:0] s, input logic [9:0] pv, input logic [9:0] nv);
    logic [9:0] op;
    op = (pv > nv) ? 10'h000 : 10'h3ff;
    @(posedge pclk);
    pp0 <= s[3] ? op : pv;
    pp1 <= s[3] ? pv : op;
    np0 <= (s[1:0] == 2'h0) ? nv : ~op;
    np1 <= (s[1:0] == 2'h1) ? nv : ~op;
    vref <= (s[1:0] == 2'h2) ? nv : ~op;
    dac <= (s[1:0] == 2'h3) ? nv : ~op;
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge pclk);
    #1;
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc(A_CTRL, 8'h00, 1'b0);
    rdc(A_IRQ, 8'h00, 1'b0);
    rdc(A_STAT, 8'h00, 1'b0);
    rdc(8'h04, 8'h00, 1'b1);
    wr(A_SEL, 8'hff);
    rdc(A_SEL, 8'h8b, 1'b0);
    apb(1'b1, A_SEL, 8'h00, 4'h0);
    rdc(A_SEL, 8'h8b, 1'b0);
    wr(A_CTRL, 8'h01);
    foreach (rows[i]) begin
      wr(A_SEL, rows[i].sel);
      pins(rows[i].sel, rows[i].pv, rows[i].nv);
      settle(6);
      chk1(comparator_result, rows[i].exp);
      chk1(comparator_on, 1'b1);
      chk32({29'h0, positive_source_sel, negative_source_sel}, {29'h0, rows[i].sel[3], rows[i].sel[1:0]});
      wr(A_STAT, 8'h01);
      rdc(A_STAT, {3'h0, rows[i].exp, 4'h0}, 1'b0);
    end
    wr(A_SEL, 8'h00);
    wr(A_IRQ, 8'h01);
    pins(8'h00, 10'h100, 10'h200);
    settle(6);
    wr(A_STAT, 8'h01);
    pins(8'h00, 10'h200, 10'h100);
    settle(2);
    chk1(comparator_result, 1'b0);
    settle(1);
    chk1(comparator_result, 1'b1);
    settle(1);
    chk1(irq, 1'b0);
    settle(1);
    chk1(irq, 1'b1);
    for (int m = 0; m < 4; m++) begin
      wr(A_CTRL, 8'h01 | (8'(m) << 4));
      pins(8'h00, 10'h100, 10'h200);
      settle(6);
      wr(A_STAT, 8'h01);
      pins(8'h00, 10'h200, 10'h100);
      settle(6);
      rdc(A_STAT, {3'h0, 1'b1, 3'h0, m == 0 || m == 3}, 1'b0);
      chk1(irq, m == 0 || m == 3);
      wr(A_STAT, 8'h00);
      rdc(A_STAT, {3'h0, 1'b1, 3'h0, m == 0 || m == 3}, 1'b0);
      wr(A_STAT, 8'h01);
      pins(8'h00, 10'h100, 10'h200);
      settle(6);
      rdc(A_STAT, {7'h0, m == 0 || m == 2}, 1'b0);
    end
    wr(A_CTRL, 8'h01);
    wr(A_IRQ, 8'h00);
    pins(8'h00, 10'h200, 10'h100);
    settle(6);
    chk1(irq, 1'b0);
    rdc(A_STAT, 8'h11, 1'b0);
    wr(A_IRQ, 8'h01);
    settle(2);
    chk1(irq, 1'b1);
    wr(A_STAT, 8'h01);
    settle(2);
    chk1(irq, 1'b0);
    wr(A_CTRL, 8'h81);
    @(posedge pclk);
    standby_sleep <= 1'b1;
    pins(8'h00, 10'h100, 10'h200);
    settle(6);
    chk1(comparator_result, 1'b0);
    rdc(A_STAT, 8'h10, 1'b0);
    @(posedge pclk);
    standby_sleep <= 1'b0;
    clk_en <= 1'b0;
    pins(8'h00, 10'h200, 10'h100);
    settle(6);
    chk1(comparator_result, 1'b0);
    @(posedge pclk);
    clk_en <= 1'b1;
    wr(A_CTRL, 8'h00);
    settle(6);
    chk1(comparator_on, 1'b0);
    chk1(comparator_result, 1'b0);
    report_and_stop();
  end
endmodule
